// *** host_model.sv ***
// host controller model driving the sram command inputs
`timescale 1ns/1ps
module host_model (
    input  wire logic                      i_mclk,
    output logic [2:0]                     o_en,
    output logic                           o_adv,
    output logic                           o_write_n,
    output logic                           o_cq_n,
    output logic [sram_in_pkg::ADDR_W-1:0] o_addr,
    output logic [sram_in_pkg::LANES-1:0]  o_lanes_n,
    output logic [sram_in_pkg::DATA_W-1:0] o_wdata
);
    // --------------
    // command driver
    // --------------
    initial {o_en, o_adv, o_write_n, o_cq_n, o_addr, o_lanes_n, o_wdata} = '0;

    // en is {first low, high, second low}; a deselect keeps advance low
    task drive(input logic [2:0] en, input logic adv, input logic wr_n, input logic cq_n,
               input logic [18:0] a, input logic [3:0] ln, input logic [35:0] wd);
        @(posedge i_mclk);
        {o_en, o_adv, o_write_n, o_cq_n} <= {en, adv, wr_n, cq_n};
        {o_addr, o_lanes_n, o_wdata} <= {a, ln, wd};
    endtask : drive
endmodule : host_model

// *** sram_cmd_if.sv ***
// captured command carried from the input stage to the storage array
`timescale 1ns/1ps
interface sram_cmd_if;
    logic                             wr_en;
    logic [sram_in_pkg::LANES-1:0]    lane_en;
    logic [sram_in_pkg::IDX_W-1:0]    wr_idx;
    logic [sram_in_pkg::DATA_W-1:0]   wr_data;
    logic [sram_in_pkg::IDX_W-1:0]    rd_idx;
    logic [sram_in_pkg::DATA_W-1:0]   rd_data;

    modport ctrl (output wr_en, output lane_en, output wr_idx, output wr_data,
                  output rd_idx, input rd_data);
    modport mem  (input wr_en, input lane_en, input wr_idx, input wr_data,
                  input rd_idx, output rd_data);
endinterface : sram_cmd_if

// *** sram_cmd_inputs.sv ***
// command and address input stage of a pipelined burst sram
`timescale 1ns/1ps
// Operation
// (R1) address, including low burst bits, captured on rising edge selects location
// (R2) low lane select with write enable writes its byte and parity bit
// (R3) lane selects sampled on rising edge, low enables lane
// (R4) write enable sampled only when clock qualify is low
// (R5) controller drives write enable low to start a write
// (R6) advance high on qualified edge steps the burst counter
// (R7) advance low loads presented address as new access
// (R8) controller should load a fresh address after deselect
// (R9) all synchronous inputs captured on the rising clock edge
// (R10) clock qualify high leaves all state unchanged
// (R11) first enable, active low, sampled as a select term
// (R12) second enable, active high, sampled as a select term
// (R13) third enable, active low, sampled as a select term
// (R14) clock qualify high stretches the cycle, no deselect
// (R15) read data comes from address captured at previous edge
// (R16) burst steps interleaved when strap high, linear when low
// (R17) selected only with first and third low, second high
module sram_cmd_inputs (
    input  wire logic                              i_mclk,
    input  wire logic                              i_rstn,
    input  wire logic [sram_in_pkg::ADDR_W-1:0]    i_addr,
    input  wire logic [sram_in_pkg::LANES-1:0]     i_byte_lane_select_n,
    input  wire logic                              i_write_n,
    input  wire logic                              i_advance_or_load,
    input  wire logic                              i_clock_qualify_n,
    input  wire logic                              i_select_low_first,
    input  wire logic                              i_select_high,
    input  wire logic                              i_select_low_second,
    input  wire logic                              i_burst_interleaved,
    input  wire logic [sram_in_pkg::DATA_W-1:0]    i_wdata,
    output logic      [sram_in_pkg::DATA_W-1:0]    o_rdata,
    output logic                                   o_rdata_valid,
    output logic                                   o_selected
);
    sram_cmd_if cmd ();

    sram_in_pkg::access_t               op;
    logic [sram_in_pkg::ADDR_W-1:0]     base;
    logic [1:0]                         burst_cnt;
    logic [sram_in_pkg::LANES-1:0]      lane_en;
    logic                               qual;
    logic                               sel_now;
    logic [1:0]                         next_cnt;
    logic [1:0]                         low_bits;
    logic [sram_in_pkg::ADDR_W-1:0]     cur_addr;

    // ------------------------------------------------------------
    // selection and address formation
    // ------------------------------------------------------------
    assign qual    = ~i_clock_qualify_n;                      // (R10)
    assign sel_now = ~i_select_low_first & i_select_high      // (R11) (R12)
                   & ~i_select_low_second;                    // (R13) (R17)
    assign next_cnt = burst_cnt + sram_in_pkg::BURST_ONE;

    always_comb begin
        // interleave xors the count, linear adds it
        if (i_burst_interleaved) begin                        // (R16)
            low_bits = base[1:0] ^ burst_cnt;
        end else begin
            low_bits = base[1:0] + burst_cnt;
        end
        cur_addr = {base[sram_in_pkg::ADDR_W-1:2], low_bits};
    end

    // ------------------------------------------------------------
    // command capture
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn) begin       // (R9)
        if (!i_rstn) begin
            op        <= sram_in_pkg::ST_IDLE;
            base      <= sram_in_pkg::ADDR_RST;
            burst_cnt <= 2'h0;
            lane_en   <= 4'h0;
        end else if (qual) begin                              // (R14)
            if (i_advance_or_load) begin                      // (R6)
                // continue previous access type when stepping
                burst_cnt <= next_cnt;
                if (op == sram_in_pkg::ST_WRITE) begin
                    lane_en <= ~i_byte_lane_select_n;         // (R3)
                end
            end else if (sel_now) begin                       // (R7)
                base      <= i_addr;                          // (R1)
                burst_cnt <= 2'h0;
                lane_en   <= ~i_byte_lane_select_n;           // (R3)
                op        <= i_write_n ? sram_in_pkg::ST_READ // (R4)
                                       : sram_in_pkg::ST_WRITE;
            end else begin
                op <= sram_in_pkg::ST_IDLE;                   // (R17)
            end
        end
    end

    // ------------------------------------------------------------
    // storage and pipelined read output
    // ------------------------------------------------------------
    assign cmd.wr_en   = qual && (op == sram_in_pkg::ST_WRITE);
    assign cmd.lane_en = lane_en;                             // (R2)
    assign cmd.wr_idx  = cur_addr[sram_in_pkg::IDX_W-1:0];
    assign cmd.wr_data = i_wdata;
    assign cmd.rd_idx  = cur_addr[sram_in_pkg::IDX_W-1:0];

    sram_store u_store (
        .i_mclk (i_mclk),
        .bus    (cmd.mem)
    );

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata       <= sram_in_pkg::DATA_RST;
            o_rdata_valid <= 1'b0;
            o_selected    <= 1'b0;
        end else if (qual) begin                              // (R10)
            o_rdata       <= cmd.rd_data;                     // (R15)
            o_rdata_valid <= (op == sram_in_pkg::ST_READ);
            o_selected    <= (op != sram_in_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_stall;
        i_clock_qualify_n;
    endsequence

    sequence s_qual;
        qual;
    endsequence

    // a selected load edge, of either access type
    sequence s_load;
        qual && !i_advance_or_load && sel_now;
    endsequence

    sequence s_load_rd;
        qual && !i_advance_or_load && sel_now && i_write_n;
    endsequence

    sequence s_load_wr;
        qual && !i_advance_or_load && sel_now && !i_write_n;
    endsequence

    sequence s_desel;
        qual && !i_advance_or_load && !sel_now;
    endsequence

    // ------------------------------------------------------------
    // stall checks
    // ------------------------------------------------------------
    stall_count_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R10)
        s_stall |=> $stable(burst_cnt) && $stable(lane_en))
        else $error("burst state moved on unqualified edge");
    stall_valid_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R14)
        s_stall |=> $stable(o_rdata_valid))
        else $error("read flag moved on unqualified edge");
    write_gate_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R10)
        !qual |-> !cmd.wr_en)
        else $error("array written on unqualified edge");

    // ------------------------------------------------------------
    // load and select checks
    // ------------------------------------------------------------
    addr_form_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R1)
        s_load |=> cur_addr == $past(i_addr))
        else $error("loaded address not used");
    sel_follows_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R17)
        s_load ##1 s_qual |=> o_selected)
        else $error("selected flag missing after load");
    desel_out_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R17)
        s_desel ##1 s_qual |=> !o_selected)
        else $error("selected flag left after deselect");
    read_pipe_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R15)
        s_load_rd ##1 s_qual |=> o_rdata_valid)
        else $error("read data not flagged after read load");
    write_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R4)
        s_load_wr ##1 s_qual |=> !o_rdata_valid)
        else $error("read flag raised by a write");

    // ------------------------------------------------------------
    // burst and output checks
    // ------------------------------------------------------------
    wrap_count_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R6)
        qual && i_advance_or_load && burst_cnt == 2'h3 |=> burst_cnt == 2'h0)
        else $error("burst counter did not wrap");
    step_keeps_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R6)
        qual && i_advance_or_load |=> $stable(base) && $stable(op))
        else $error("step changed the access");
    first_beat_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R16)
        burst_cnt == 2'h0 |-> cur_addr == base)
        else $error("first beat not at loaded address");
    read_data_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R15)
        s_qual |=> o_rdata == $past(cmd.rd_data))
        else $error("read data not from previous address");

    hold_on_stall_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R10)
        s_stall |=> $stable(o_rdata) && $stable(o_selected))
        else $error("outputs moved on unqualified edge");
    keep_op_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R14)
        s_stall |=> $stable(op) && $stable(base))
        else $error("state moved on unqualified edge");
    load_addr_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R7)
        qual && !i_advance_or_load && sel_now |=> base == $past(i_addr) && burst_cnt == 2'h0)
        else $error("address not loaded");
    step_cnt_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R6)
        qual && i_advance_or_load |=> burst_cnt == $past(burst_cnt) + 2'h1)
        else $error("burst counter not stepped");
    write_start_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R4)
        qual && !i_advance_or_load && sel_now && !i_write_n |=> op == sram_in_pkg::ST_WRITE)
        else $error("write not started");
    deselect_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R17)
        qual && !i_advance_or_load && !sel_now |=> op == sram_in_pkg::ST_IDLE)
        else $error("not deselected");
    lane_mask_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R3)
        qual && !i_advance_or_load && sel_now |=> lane_en == ~$past(i_byte_lane_select_n))
        else $error("lane mask wrong");
    read_valid_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // (R15)
        qual && op == sram_in_pkg::ST_READ |=> o_rdata_valid)
        else $error("read data not flagged");
endmodule : sram_cmd_inputs

// *** sram_in_pkg.sv ***
// constants and types for the synchronous burst sram command input stage
package sram_in_pkg;
    localparam int ADDR_W  = 19;
    localparam int LANES   = 4;
    localparam int BYTE_W  = 8;
    localparam int LANE_W  = BYTE_W + 1;
    localparam int DATA_W  = LANES * LANE_W;
    localparam int DEPTH   = 16;
    localparam int IDX_W   = 4;
    localparam logic [1:0] BURST_ONE = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
    localparam logic [LANES-1:0]  LANES_OFF = 4'hF;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_READ  = 3'h2,
        ST_WRITE = 3'h4
    } access_t;
endpackage : sram_in_pkg

// *** sram_store.sv ***
// flip-flop storage array with per-lane write masks
`timescale 1ns/1ps
module sram_store (
    input  wire logic i_mclk,
    sram_cmd_if.mem   bus
);
    // ------------------------------------------------------------
    // lane writes
    // ------------------------------------------------------------
    // one array per lane keeps every variable under a single process
    genvar g;
    generate
        for (g = 0; g < sram_in_pkg::LANES; g++) begin : g_lane
            logic [sram_in_pkg::LANE_W-1:0] lane_mem [sram_in_pkg::DEPTH];

            always_ff @(posedge i_mclk) begin
                // each lane covers its byte and its parity bit
                if (bus.wr_en && bus.lane_en[g]) begin // (R2)
                    lane_mem[bus.wr_idx] <=
                        bus.wr_data[g*sram_in_pkg::LANE_W +: sram_in_pkg::LANE_W];
                end
            end

            assign bus.rd_data[g*sram_in_pkg::LANE_W +: sram_in_pkg::LANE_W] =
                lane_mem[bus.rd_idx];
        end
    endgenerate
endmodule : sram_store

// *** sync_burst_sram_cmd_inputs_test.sv ***
// self-checking bench for the burst sram command input stage
`timescale 1ns/1ps
module sync_burst_sram_cmd_inputs_test;
    // -----------------
    // signals and clock
    // -----------------
    localparam logic [35:0] P = 36'h123456789;
    localparam logic [35:0] Q = 36'hFEDCBA987;
    localparam logic [35:0] M = 36'h007FC01FF;
    localparam logic [2:0] ON = 3'h2;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic strap = 1'b0;
    logic adv, write_n, cq_n, rvalid, sel;
    logic [2:0] en;
    logic [3:0] lanes_n;
    logic [18:0] addr;
    logic [35:0] wdata, rdata;
    logic [35:0] exp_d [4];
    logic [2:0] offs [3] = '{3'h6, 3'h0, 3'h3};
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 400) begin
            n_mismatch++;
            stop_test();
        end
    end

    host_model host (.i_mclk(mclk), .o_en(en), .o_adv(adv), .o_write_n(write_n),
        .o_cq_n(cq_n), .o_addr(addr), .o_lanes_n(lanes_n), .o_wdata(wdata));
    sram_cmd_inputs uut (.i_mclk(mclk), .i_rstn(rstn), .i_addr(addr),
        .i_byte_lane_select_n(lanes_n), .i_write_n(write_n), .i_advance_or_load(adv),
        .i_clock_qualify_n(cq_n), .i_select_low_first(en[2]), .i_select_high(en[1]),
        .i_select_low_second(en[0]), .i_burst_interleaved(strap), .i_wdata(wdata),
        .o_rdata(rdata), .o_rdata_valid(rvalid), .o_selected(sel));

    // -----
    // tasks
    // -----
    task check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // burst write of n beats, data one cycle behind each command edge
    task wr(input logic [18:0] a, input logic [3:0] ln, input int n);
        host.drive(ON, 1'b0, 1'b0, 1'b0, a, ln, '0);
        for (int k = 1; k <= n; k++)
            host.drive(k < n ? ON : 3'h0, k < n, 1'b1, 1'b0, a, ln, exp_d[k-1]);
    endtask : wr

    task rd(input logic [2:0] e, input logic [18:0] a, input int n);
        host.drive(e, 1'b0, 1'b1, 1'b0, a, 4'hF, '0);
        for (int k = 1; k < n + 3; k++) begin
            host.drive(k < n ? ON : 3'h0, k < n, 1'b1, 1'b0, a, 4'hF, '0);
            if (k >= 2 && k <= n + 1) begin
                #1;
                check("valid", 36'(rvalid), 36'(e === ON));
                check("selected", 36'(sel), 36'(e === ON));
                if (e === ON) check("rdata", rdata, exp_d[k-2]);
            end
        end
    endtask : rd

    task stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        exp_d[0] = P;
        wr(19'h00005, 4'h0, 1);
        rd(ON, 19'h00005, 1);
        exp_d[0] = Q;
        wr(19'h00005, 4'hA, 1);
        exp_d[0] = (Q & M) | (P & ~M);
        rd(ON, 19'h00005, 1);
        host.drive(ON, 1'b0, 1'b0, 1'b1, 19'h00005, 4'h0, '0);
        host.drive(3'h0, 1'b0, 1'b1, 1'b1, 19'h00005, 4'h0, P);
        rd(ON, 19'h00005, 1);
        foreach (offs[i]) rd(offs[i], 19'h00005, 1);
        host.drive(ON, 1'b0, 1'b1, 1'b0, 19'h00005, 4'hF, '0);
        repeat (4) begin
            host.drive(ON, 1'b1, 1'b1, 1'b1, 19'h00005, 4'hF, '0);
            #1 check("held", 36'(rvalid), 36'h000000000);
        end
        repeat (3) host.drive(3'h0, 1'b0, 1'b1, 1'b0, 19'h00005, 4'hF, '0);
        #1 check("stretched", rdata, exp_d[0]);
        for (int k = 0; k < 4; k++) exp_d[k] = P + 36'(k);
        wr(19'h00008, 4'h0, 4);
        for (int k = 0; k < 4; k++) exp_d[k] = P + 36'((k + 1) % 4);
        rd(ON, 19'h00009, 4);
        @(posedge mclk) strap <= 1'b1;
        for (int k = 0; k < 4; k++) exp_d[k] = P + 36'(k ^ 1);
        rd(ON, 19'h00009, 4);
        stop_test();
    end
endmodule : sync_burst_sram_cmd_inputs_test
